// >>> src/tsc_defs.vh
// constants for the three-channel sync compare capture timer
// How it works
// - 8-bit sync select register, zero on reset/standby
// - bit n makes channel n synchronous
// - sync bits 7..3 read zero, write zero
// - write to a synced counter presets all synced counters together
// - counters and general registers: whole-word access only
// - 8-bit registers accept byte or word access
// - buffered compare match copies buffer into register
// - buffered capture shifts old value into buffer
// - channel 1 and 2 cascade to 32 bits
// - PWM output, any duty, levels from IO control
// - phase counting on channels 1 and 2
// - start bit set means counter runs
// - wrap to zero sets overflow, keeps counting
// - overflow flag with enable raises interrupt
// - period match sets flag, clears counter, interrupts if enabled
// - match drives pin low/high/toggle, initial level before
// - match to current level leaves pin unchanged
// - capture counter on selected pin edge
// - channels 0,1 capture on other channel events
// - counters reset to zero on reset/standby
// - general registers reset to all ones
// - stopping counter holds the compare output level
`ifndef TSC_DEFS_VH
`define TSC_DEFS_VH
`define TSC_CH_GLOBAL 2'h3
`define TSC_GLB_WORD 4'h0
`define TSC_WD_CTRL 4'h0
`define TSC_WD_IO 4'h1
`define TSC_WD_IRQ 4'h2
`define TSC_WD_CNT 4'h3
`define TSC_WD_GRA 4'h4
`define TSC_WD_GRB 4'h5
`define TSC_WD_GRC 4'h6
`define TSC_WD_GRD 4'h7
`define TSC_CTRL_CKS 2:0
`define TSC_CTRL_EDGE 4:3
`define TSC_CTRL_CLR 7:5
`define TSC_MODE_PWM 0
`define TSC_MODE_PHASE 1
`define TSC_MODE_BUFA 4
`define TSC_MODE_BUFB 5
`define TSC_IO_CAP 3
`define TSC_IO_INIT 2
`define TSC_IO_ALT 2
`define TSC_IO_ACT 1:0
`define TSC_CLR_GRA 3'h1
`define TSC_CLR_GRB 3'h2
`define TSC_CLR_SYNC 3'h3
`define TSC_CLR_GRC 3'h5
`define TSC_CLR_GRD 3'h6
`define TSC_CKS_EXTA 3'h4
`define TSC_CKS_EXTB 3'h5
`define TSC_CKS_EXTC 3'h6
`define TSC_CKS_CASC 3'h7
`define TSC_EDGE_RISE 2'h0
`define TSC_EDGE_FALL 2'h1
`define TSC_ACT_LOW 2'h1
`define TSC_ACT_HIGH 2'h2
`define TSC_ACT_TOG 2'h3
`define TSC_ACT_OFF 2'h0
`define TSC_ST_OVF 4
`define TSC_ST_UNF 5
`define TSC_SYNC_RST 3'h0
`define TSC_START_RST 3'h0
`define TSC_CNT_RST 16'h0000
`define TSC_CNT_MAX 16'hFFFF
`define TSC_GR_RST 16'hFFFF
`endif

// >>> src/tsc_gr_unit.v
// one general register: compare match, capture and buffer load
`timescale 1ns/100ps
`include "tsc_defs.vh"
module tsc_gr_unit (
  input wire core_clk,
  input wire sys_rst,
  input wire en,
  input wire [3:0] io,
  input wire [15:0] cnt,
  input wire tick,
  input wire pin_sync,
  input wire alt_trig,
  input wire wr_en,
  input wire [15:0] wr_val,
  input wire ld_en,
  input wire [15:0] ld_val,
  output wire [15:0] gr_val,
  output wire match,
  output wire capt
);
  reg [15:0] gr_r;
  reg prev_r;
  reg edge_hit;
  wire rise = pin_sync & ~prev_r;
  wire fall = ~pin_sync & prev_r;

  // edge select for capture
  always @* begin
    case (io[`TSC_IO_ACT])
      `TSC_EDGE_RISE: edge_hit = rise;
      `TSC_EDGE_FALL: edge_hit = fall;
      default: edge_hit = rise | fall;
    endcase
  end

  assign capt = en & io[`TSC_IO_CAP] & (io[`TSC_IO_ALT] ? alt_trig : edge_hit);
  assign match = en & ~io[`TSC_IO_CAP] & tick & (cnt == gr_r);
  assign gr_val = gr_r;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      gr_r <= `TSC_GR_RST;
      prev_r <= 1'b0;
    end else begin
      prev_r <= pin_sync;
      if (capt) begin
        gr_r <= cnt;
      end else if (ld_en) begin
        gr_r <= ld_val;
      end else if (wr_en) begin
        gr_r <= wr_val;
      end
    end
  end
endmodule

// >>> src/tsc_timer_top.v
// three-channel timer: bus registers, counters, sync, pins
`timescale 1ns/100ps
`include "tsc_defs.vh"
module tsc_timer_top (
  input wire core_clk,
  input wire sys_rst,
  input wire standby,
  input wire [6:0] bus_addr,
  input wire bus_wr,
  input wire bus_rd,
  input wire [1:0] bus_be,
  input wire [15:0] bus_wdata,
  output wire [15:0] bus_rdata,
  input wire [3:0] external_clock_pin,
  input wire [7:0] cc_pin_in,
  output wire [7:0] cc_pin_out,
  output wire [7:0] cc_pin_oe,
  output wire [2:0] irq
);
  wire rst_i = sys_rst | standby;
  wire [1:0] a_ch = bus_addr[6:5];
  wire [3:0] a_wd = bus_addr[4:1];
  wire wr_hi = bus_wr & bus_be[1];
  wire wr_lo = bus_wr & bus_be[0];
  wire wr_w = bus_wr & (&bus_be);
  wire glb = (a_ch == `TSC_CH_GLOBAL) & (a_wd == `TSC_GLB_WORD);

  reg [2:0] channel_sync_select;
  reg [2:0] counter_start_reg;
  reg [5:0] pre_r;
  reg [3:0] ext_s1_r, ext_s2_r, ext_s3_r;
  reg [7:0] cc_s1_r, cc_s2_r;
  reg [15:0] rdata_r;
  reg [15:0] rd_val;
  reg [2:0] gi;

  wire [23:0] ctrl_all, mode_all;
  wire [47:0] io_all;
  wire [17:0] ien_all, stat_all;
  wire [47:0] cnt_all;
  wire [127:0] gr_all;
  wire [7:0] match, capt;
  wire [11:0] ev_all;
  wire [2:0] tick_all, ovf_raw, unf_raw, syn_src, wr_cnt, io_wr;

  // global start and sync select, 8-bit registers on one word
  always @(posedge core_clk) begin
    if (rst_i) begin
      counter_start_reg <= `TSC_START_RST;
      channel_sync_select <= `TSC_SYNC_RST;
    end else begin
      if (glb & wr_hi) begin
        counter_start_reg <= bus_wdata[10:8];
      end
      if (glb & wr_lo) begin
        channel_sync_select <= bus_wdata[2:0];
      end
    end
  end

  // prescaler and input synchronisers
  always @(posedge core_clk) begin
    if (rst_i) begin
      pre_r <= 6'h00;
      ext_s1_r <= 4'h0;
      ext_s2_r <= 4'h0;
      ext_s3_r <= 4'h0;
      cc_s1_r <= 8'h00;
      cc_s2_r <= 8'h00;
    end else begin
      pre_r <= pre_r + 6'h01;
      ext_s1_r <= external_clock_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      cc_s1_r <= cc_pin_in;
      cc_s2_r <= cc_s1_r;
    end
  end

  wire [3:0] div_t = {&pre_r, &pre_r[3:0], &pre_r[1:0], 1'b1};
  wire [3:0] ext_rise = ext_s2_r & ~ext_s3_r;
  wire [3:0] ext_fall = ~ext_s2_r & ext_s3_r;
  wire preset_any = |(wr_cnt & channel_sync_select);
  wire sync_any = |syn_src;

  assign ev_all[3:0] = match[3:0] | capt[3:0];
  assign ev_all[7:4] = {2'h0, match[5:4] | capt[5:4]};
  assign ev_all[11:8] = {2'h0, match[7:6] | capt[7:6]};

  genvar c, g;
  generate
    for (c = 0; c < 3; c = c + 1) begin : gen_ch
      localparam [1:0] CH = c;
      localparam PA = (c == 2) ? 2 : 0;
      reg [7:0] ctrl_r, mode_r;
      reg [15:0] io_r;
      reg [5:0] ien_r, stat_r;
      reg [15:0] cnt_r;
      reg io_wr_r, irq_r;
      reg src_t, clr_own;
      wire sel = (a_ch == CH);
      wire [2:0] cks = ctrl_r[`TSC_CTRL_CKS];
      wire [1:0] edg = ctrl_r[`TSC_CTRL_EDGE];
      wire [3:0] ext_ev = edg[1] ? (ext_rise | ext_fall) :
                          (edg[0] ? ext_fall : ext_rise);
      wire ph_en = (c != 0) & mode_r[`TSC_MODE_PHASE];
      wire ph_step = (ext_s2_r[PA] ^ ext_s3_r[PA]) | (ext_s2_r[PA+1] ^ ext_s3_r[PA+1]);
      wire ph_up = ext_s3_r[PA] ^ ext_s2_r[PA+1];
      wire casc = (c == 1) & (cks == `TSC_CKS_CASC);
      wire tick = counter_start_reg[c] & (ph_en ? ph_step : src_t);
      wire up = ph_en ? ph_up : (casc ? ~unf_raw[2] : 1'b1);
      wire [3:0] ev = ev_all[4*c +: 4];
      wire clr = clr_own | ((ctrl_r[`TSC_CTRL_CLR] == `TSC_CLR_SYNC) &
                 channel_sync_select[c] & sync_any);
      wire ld = wr_cnt[c] | (channel_sync_select[c] & preset_any);
      wire ovf = ovf_raw[c] & ~clr & ~ld;
      wire unf = unf_raw[c] & ~clr & ~ld;
      wire st_clr_wr = sel & (a_wd == `TSC_WD_IRQ) & wr_lo;
      wire [5:0] st_keep = st_clr_wr ? bus_wdata[5:0] : 6'h3F;
      wire [5:0] st_set = {unf, ovf, ev};

      always @* begin
        case (cks)
          3'h0, 3'h1, 3'h2, 3'h3: src_t = div_t[cks[1:0]];
          `TSC_CKS_EXTA: src_t = ext_ev[0];
          `TSC_CKS_EXTB: src_t = ext_ev[1];
          `TSC_CKS_EXTC: src_t = ext_ev[2];
          `TSC_CKS_CASC: src_t = (c == 1) ? (ovf_raw[2] | unf_raw[2]) : ext_ev[3];
          default: src_t = 1'b0;
        endcase
      end

      always @* begin
        case (ctrl_r[`TSC_CTRL_CLR])
          `TSC_CLR_GRA: clr_own = ev[0];
          `TSC_CLR_GRB: clr_own = ev[1];
          `TSC_CLR_GRC: clr_own = ev[2];
          `TSC_CLR_GRD: clr_own = ev[3];
          default: clr_own = 1'b0;
        endcase
      end

      assign tick_all[c] = tick;
      assign ovf_raw[c] = tick & up & (cnt_r == `TSC_CNT_MAX);
      assign unf_raw[c] = tick & ~up & (cnt_r == `TSC_CNT_RST);
      assign syn_src[c] = clr_own & channel_sync_select[c];
      assign wr_cnt[c] = sel & (a_wd == `TSC_WD_CNT) & wr_w;
      assign io_wr[c] = io_wr_r;
      assign ctrl_all[8*c +: 8] = ctrl_r;
      assign mode_all[8*c +: 8] = mode_r;
      assign io_all[16*c +: 16] = io_r;
      assign ien_all[6*c +: 6] = ien_r;
      assign stat_all[6*c +: 6] = stat_r;
      assign cnt_all[16*c +: 16] = cnt_r;
      assign irq[c] = irq_r;

      always @(posedge core_clk) begin
        if (rst_i) begin
          ctrl_r <= 8'h00;
          mode_r <= 8'h00;
          io_r <= 16'h0000;
          ien_r <= 6'h00;
          stat_r <= 6'h00;
          cnt_r <= `TSC_CNT_RST;
          io_wr_r <= 1'b0;
          irq_r <= 1'b0;
        end else begin
          if (sel & (a_wd == `TSC_WD_CTRL) & wr_hi) begin
            ctrl_r <= bus_wdata[15:8];
          end
          if (sel & (a_wd == `TSC_WD_CTRL) & wr_lo) begin
            mode_r <= bus_wdata[7:0];
          end
          if (sel & (a_wd == `TSC_WD_IO) & wr_hi) begin
            io_r[15:8] <= bus_wdata[15:8];
          end
          if ((c == 0) & sel & (a_wd == `TSC_WD_IO) & wr_lo) begin
            io_r[7:0] <= bus_wdata[7:0];
          end
          if (sel & (a_wd == `TSC_WD_IRQ) & wr_hi) begin
            ien_r <= bus_wdata[13:8];
          end
          io_wr_r <= sel & (a_wd == `TSC_WD_IO) & (wr_hi | wr_lo);
          // hardware set wins over a zero write
          stat_r <= (stat_r & st_keep) | st_set;
          irq_r <= |(stat_r & ien_r);
          if (ld) begin
            cnt_r <= bus_wdata;
          end else if (clr) begin
            cnt_r <= `TSC_CNT_RST;
          end else if (tick) begin
            cnt_r <= up ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
          end
        end
      end
    end

    for (g = 0; g < 8; g = g + 1) begin : gen_gr
      localparam GC = (g < 4) ? 0 : ((g < 6) ? 1 : 2);
      localparam GL = (g < 4) ? g : ((g - 4) % 2);
      localparam IOB = (g == 2) ? 0 : (g == 3) ? 4 :
                       (16 * GC + 8 + 4 * GL);
      localparam GQ = (g < 4) ? (g ^ 2) : g;
      localparam GP = (g % 2 == 0) ? g + 1 : g;
      localparam PIOB = (g == 2) ? 4 : (16 * GC + 12);
      localparam [3:0] WD = 4 + GL;
      wire [3:0] io = io_all[IOB +: 4];
      wire [3:0] pio = io_all[PIOB +: 4];
      wire pwm = mode_all[8 * GC + `TSC_MODE_PWM];
      wire bufm = mode_all[(g % 2 == 0) ? `TSC_MODE_BUFA : `TSC_MODE_BUFB];
      wire en = (g == 2 || g == 3) ? ~bufm : 1'b1;
      wire ld_en = (g < 2) ? (bufm & match[g]) : (g < 4) ? (bufm & capt[GQ]) : 1'b0;
      wire alt = (GC == 0) ? tick_all[1] : ((GC == 1) ? match[0] : 1'b0);
      wire odd = (g % 2 == 1);
      wire m_own = match[g];
      wire m_par = match[GP];
      reg lvl_r, oe_r;
      wire [15:0] gr_v;

      tsc_gr_unit u_gr (
        .core_clk(core_clk),
        .sys_rst(rst_i),
        .en(en),
        .io(io),
        .cnt(cnt_all[16*GC +: 16]),
        .tick(tick_all[GC]),
        .pin_sync(cc_s2_r[g]),
        .alt_trig(alt),
        .wr_en((a_ch == GC) & (a_wd == WD) & wr_w),
        .wr_val(bus_wdata),
        .ld_en(ld_en),
        .ld_val(gr_all[16*GQ +: 16]),
        .gr_val(gr_v),
        .match(match[g]),
        .capt(capt[g])
      );
      assign gr_all[16*g +: 16] = gr_v;
      assign cc_pin_out[g] = lvl_r;
      assign cc_pin_oe[g] = oe_r;

      always @(posedge core_clk) begin
        if (rst_i) begin
          lvl_r <= 1'b0;
          oe_r <= 1'b0;
        end else begin
          oe_r <= en & ~io[`TSC_IO_CAP] & (io[`TSC_IO_ACT] != `TSC_ACT_OFF) & ~(pwm & odd);
          if (io_wr[GC] & ~counter_start_reg[GC]) begin
            lvl_r <= io[`TSC_IO_INIT];
          end else if (pwm & ~odd & m_own & m_par) begin
            lvl_r <= lvl_r;
          end else if (m_own & ~(pwm & odd)) begin
            lvl_r <= act(lvl_r, io[`TSC_IO_ACT]);
          end else if (pwm & ~odd & m_par) begin
            lvl_r <= act(lvl_r, pio[`TSC_IO_ACT]);
          end
        end
      end
    end
  endgenerate

  // level after a compare match
  function act;
    input lvl;
    input [1:0] code;
    begin
      case (code)
        `TSC_ACT_LOW: act = 1'b0;
        `TSC_ACT_HIGH: act = 1'b1;
        `TSC_ACT_TOG: act = ~lvl;
        default: act = lvl;
      endcase
    end
  endfunction

  // read mux
  always @* begin
    rd_val = 16'h0000;
    gi = 3'h0;
    case (a_ch)
      2'h0: gi = a_wd[2:0] - 3'h4;
      2'h1: gi = a_wd[2:0];
      default: gi = a_wd[2:0] + 3'h2;
    endcase
    if (glb) begin
      rd_val = {5'h00, counter_start_reg, 5'h00, channel_sync_select};
    end else if (a_ch != `TSC_CH_GLOBAL) begin
      case (a_wd)
        `TSC_WD_CTRL: rd_val = {ctrl_all[{a_ch, 3'h0} +: 8], mode_all[{a_ch, 3'h0} +: 8]};
        `TSC_WD_IO: rd_val = io_all[{a_ch, 4'h0} +: 16];
        `TSC_WD_IRQ: rd_val = {2'h0, ien_all[6*a_ch +: 6], 2'h0, stat_all[6*a_ch +: 6]};
        `TSC_WD_CNT: rd_val = cnt_all[{a_ch, 4'h0} +: 16];
        `TSC_WD_GRA, `TSC_WD_GRB: rd_val = gr_all[{gi, 4'h0} +: 16];
        `TSC_WD_GRC, `TSC_WD_GRD: rd_val = (a_ch == 2'h0) ? gr_all[{gi, 4'h0} +: 16] : 16'h0000;
        default: rd_val = 16'h0000;
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (rst_i) begin
      rdata_r <= 16'h0000;
    end else if (bus_rd) begin
      rdata_r <= rd_val;
    end
  end
  assign bus_rdata = rdata_r;
endmodule

// >>> sim/tsc_timer_assertions.sv
// checker: read-back, reset and pin hold relations of the timer ports
`timescale 1ns/100ps
module tsc_timer_assertions (
  input wire core_clk,
  input wire sys_rst,
  input wire standby,
  input wire [6:0] bus_addr,
  input wire bus_wr,
  input wire bus_rd,
  input wire [1:0] bus_be,
  input wire [15:0] bus_wdata,
  input wire [15:0] bus_rdata,
  input wire [7:0] cc_pin_out,
  input wire [7:0] cc_pin_oe,
  input wire [2:0] irq
);
  wire rst_any = sys_rst | standby;
  wire glob = bus_addr[6:1] == 6'h30;
  reg [2:0] start_r;
  reg [2:0] sync_r;
  reg [2:0] idle_r;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst_any);
  // snooped start and sync bytes
  always @(posedge core_clk) begin
    if (rst_any) begin
      start_r <= 3'h0;
      sync_r <= 3'h0;
    end else if (bus_wr && glob) begin
      if (bus_be[1]) start_r <= bus_wdata[10:8];
      if (bus_be[0]) sync_r <= bus_wdata[2:0];
    end
  end
  // cycles since last write with all counters stopped
  always @(posedge core_clk) begin
    if (rst_any || bus_wr || start_r != 3'h0) idle_r <= 3'h0;
    else if (idle_r != 3'h5) idle_r <= idle_r + 3'h1;
  end
  a_reset_quiet: assert property ($fell(rst_any) |-> bus_rdata == 16'h0000 && irq == 3'h0)
    else $error("bus or irq active after reset");
  a_reset_pins: assert property ($fell(rst_any) |-> cc_pin_out == 8'h00 && cc_pin_oe == 8'h00)
    else $error("pins active after reset");
  a_glob_readback: assert property (bus_rd && glob |=>
    bus_rdata == {5'h00, $past(start_r), 5'h00, $past(sync_r)}) else $error("global readback wrong");
  a_sync_upper: assert property (bus_rd && glob |=> bus_rdata[7:3] == 5'h00)
    else $error("sync upper bits not zero");
  a_rdata_stands: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("read data moved without read");
  a_unmapped_glob: assert property (bus_rd && bus_addr[6:5] == 2'h3 && bus_addr[4:1] != 4'h0 |=>
    bus_rdata == 16'h0000) else $error("unmapped global read not zero");
  a_unmapped_chan: assert property (bus_rd && bus_addr[6:5] != 2'h3 && bus_addr[4] |=>
    bus_rdata == 16'h0000) else $error("unmapped channel read not zero");
  a_stop_holds_pin: assert property (idle_r == 3'h5 |-> $stable(cc_pin_out) && $stable(cc_pin_oe))
    else $error("pin moved while stopped");
  c_glob_read: cover property (bus_rd && glob);
  c_idle: cover property (idle_r == 3'h5);
  c_irq: cover property (irq != 3'h0);
  c_pin_move: cover property ($changed(cc_pin_out));
endmodule

// >>> sim/tsc_bus_model.sv
// bus master model driving the timer register port
`timescale 1ns/100ps
module tsc_bus_model (
  input wire core_clk,
  input wire [15:0] bus_rdata,
  output reg [6:0] bus_addr,
  output reg bus_wr,
  output reg bus_rd,
  output reg [1:0] bus_be,
  output reg [15:0] bus_wdata
);
  initial begin
    bus_addr = 7'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_be = 2'h0;
    bus_wdata = 16'h0000;
  end
  task wr(input [6:0] a, input [1:0] be, input [15:0] dat);
    begin
      @(posedge core_clk);
      #1;
      bus_addr = a;
      bus_be = (a[6:5] != 2'h3 && a[4:1] > 4'h2) ? 2'h3 : be;
      bus_wdata = (a[6:1] == 6'h30) ? (dat & 16'h0707) : dat;
      bus_wr = 1'b1;
      @(posedge core_clk);
      #1;
      bus_wr = 1'b0;
      bus_addr = ~bus_addr;
      bus_wdata = ~bus_wdata;
    end
  endtask
  task rd(input [6:0] a, output [15:0] dat);
    begin
      @(posedge core_clk);
      #1;
      bus_addr = a;
      bus_rd = 1'b1;
      @(posedge core_clk);
      #1;
      bus_rd = 1'b0;
      bus_addr = ~bus_addr;
      dat = bus_rdata;
    end
  endtask
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the three-channel timer
`timescale 1ns/100ps
module tb_top;
  reg core_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg standby = 1'b0;
  reg [7:0] pin_in = 8'h00;
  reg [3:0] ext_in = 4'h0;
  wire [6:0] bus_addr;
  wire bus_wr;
  wire bus_rd;
  wire [1:0] bus_be;
  wire [15:0] bus_wdata;
  wire [15:0] bus_rdata;
  wire [7:0] pin_out;
  wire [7:0] pin_oe;
  wire [2:0] irq;
  integer n_errors = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  integer i;
  reg [31:0] seed;
  reg [15:0] d;
  reg [15:0] v;
  reg [2:0] m_sync;
  always #10 core_clk = ~core_clk;
  tsc_timer_top dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .standby(standby),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_be(bus_be),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .external_clock_pin(ext_in),
    .cc_pin_in(pin_in), .cc_pin_out(pin_out), .cc_pin_oe(pin_oe), .irq(irq));
  tsc_bus_model bm_u (.core_clk(core_clk), .bus_rdata(bus_rdata), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_be(bus_be), .bus_wdata(bus_wdata));
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask
  task chk(input [95:0] nm, input [15:0] s, input [15:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        n_errors = n_errors + 1;
        $display("BAD %0s exp %h seen %h", nm, e, s);
      end
    end
  endtask
  task rchk(input [6:0] a, input [15:0] e, input [95:0] nm);
    begin
      bm_u.rd(a, d);
      chk(nm, d, e);
    end
  endtask
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      finish_test;
    end
  end
  initial begin
    seed = $urandom(32'hAC2E);
    repeat (8) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    for (i = 0; i < 3; i = i + 1) begin
      rchk({i[1:0], 5'h06}, 16'h0000, "counter");
      rchk({i[1:0], 5'h08}, 16'hFFFF, "general");
    end
    rchk(7'h60, 16'h0000, "sync start");
    rchk(7'h62, 16'h0000, "unmapped");
    rchk(7'h10, 16'h0000, "unmapped ch");
    for (i = 0; i < 4; i = i + 1) begin
      m_sync = 3'($urandom);
      bm_u.wr(7'h60, 2'h1, {8'hFF, 5'h00, m_sync});
      rchk(7'h60, {13'h0000, m_sync}, "sync byte");
    end
    @(posedge core_clk);
    #1;
    standby = 1'b1;
    @(posedge core_clk);
    #1;
    standby = 1'b0;
    rchk(7'h60, 16'h0000, "standby");
    bm_u.wr(7'h60, 2'h1, 16'h0003);
    v = 16'($urandom);
    bm_u.wr(7'h06, 2'h3, v);
    rchk(7'h26, v, "preset");
    rchk(7'h46, 16'h0000, "no preset");
    bm_u.wr(7'h00, 2'h2, 16'h2000);
    bm_u.wr(7'h20, 2'h2, 16'h6000);
    bm_u.wr(7'h08, 2'h3, 16'h0009);
    for (i = 0; i < 4; i = i + 1) begin
      bm_u.wr(7'h02, 2'h2, {5'h00, i[0], (i[1] ? 2'h2 : 2'h1), 8'h00});
      repeat (2) @(posedge core_clk);
      #1;
      chk("init level", {14'h0000, pin_oe[0], pin_out[0]}, {15'h0001, i[0]});
      bm_u.wr(7'h06, 2'h3, 16'h0000);
      bm_u.wr(7'h60, 2'h2, 16'h0300);
      repeat (25) @(posedge core_clk);
      bm_u.wr(7'h60, 2'h2, 16'h0000);
      bm_u.rd(7'h06, v);
      chk("period", {15'h0000, v <= 16'h0009}, 16'h0001);
      rchk(7'h26, v, "sync clear");
      chk("match lvl", {15'h0000, pin_out[0]}, {15'h0000, i[1]});
    end
    bm_u.rd(7'h04, d);
    chk("match flag", {15'h0000, d[0]}, 16'h0001);
    bm_u.wr(7'h44, 2'h2, 16'h1000);
    bm_u.wr(7'h46, 2'h3, 16'hFFFA);
    bm_u.wr(7'h60, 2'h2, 16'h0400);
    repeat (10) @(posedge core_clk);
    bm_u.wr(7'h60, 2'h2, 16'h0000);
    bm_u.rd(7'h44, d);
    chk("ovf flag", {15'h0000, d[4]}, 16'h0001);
    chk("ovf irq", {15'h0000, irq[2]}, 16'h0001);
    bm_u.rd(7'h46, d);
    chk("wrap", {15'h0000, d < 16'h0010}, 16'h0001);
    bm_u.wr(7'h44, 2'h1, 16'h0000);
    repeat (3) @(posedge core_clk);
    #1;
    chk("irq clear", {13'h0000, irq}, 16'h0000);
    bm_u.wr(7'h22, 2'h2, 16'h0800);
    bm_u.wr(7'h60, 2'h2, 16'h0200);
    repeat (5 + $urandom % 8) @(posedge core_clk);
    #1;
    pin_in[4] = 1'b1;
    repeat (6) @(posedge core_clk);
    bm_u.wr(7'h60, 2'h2, 16'h0000);
    bm_u.rd(7'h28, d);
    bm_u.rd(7'h26, v);
    chk("capture", {15'h0000, d != 16'hFFFF && d <= v}, 16'h0001);
    v = 16'($urandom);
    bm_u.wr(7'h00, 2'h1, 16'h0010);
    bm_u.wr(7'h0C, 2'h3, v);
    bm_u.wr(7'h06, 2'h3, 16'h0000);
    bm_u.wr(7'h60, 2'h2, 16'h0100);
    repeat (12) @(posedge core_clk);
    bm_u.wr(7'h60, 2'h2, 16'h0000);
    rchk(7'h08, v, "buffer");
    bm_u.wr(7'h40, 2'h2, 16'h0400);
    bm_u.wr(7'h46, 2'h3, 16'h0000);
    bm_u.wr(7'h60, 2'h2, 16'h0400);
    m_sync = 3'(1 + $urandom % 7);
    for (i = 0; i < m_sync; i = i + 1) begin
      @(posedge core_clk);
      #1;
      ext_in[0] = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      ext_in[0] = 1'b0;
      repeat (2) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
    bm_u.wr(7'h60, 2'h2, 16'h0000);
    rchk(7'h46, {13'h0000, m_sync}, "ext clock");
    finish_test;
  end
endmodule
bind tsc_timer_top tsc_timer_assertions chk_u (.core_clk(core_clk), .sys_rst(sys_rst),
  .standby(standby), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
  .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe), .irq(irq));
